// ===== design/dcc_top.sv
// Control and status logic for two analog comparators, AHB-Lite slave.
// Assumes comparison bits from the analog cells and a power manager
// driving total_power_down in the hclk domain.
//
// Summary of operation
// [R1] Result high when positive input exceeds negative
// [R2] Two identical control registers, indices ACh, ADh
// [R3] Bit 0 change flag, sticky until cleared
// [R4] Bit 1 reads synchronized result
// [R5] Bit 2 routes raw result to pin
// [R6] Bit 3 selects external or internal reference
// [R7] Bit 4 selects positive input a or b
// [R8] Bit 5 enables; settle ten microseconds
// [R9] Software keeps interrupt off while settling
// [R10] Shared request gated by local, global enable
// [R11] Disabled comparator forces result high
// [R12] Software disables interrupt before disabling comparator
// [R13] Total power-down disables both comparators
// [R14] Enabled change wakes from idle, power-down
// [R15] Aux power bit 5 powers comparators down
// [R16] Service routine clears flag before returning
// [R17] Compare with previous cycle; set beats clear
`include "dcc_defs.svh"

module dcc_top #(
  parameter int SETTLE_CYC = `DCC_SETTLE_CYC
) (
  // Clock and reset
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  // AHB-Lite slave
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output      logic                  hreadyout,
  output      logic                  hresp,
  output      logic [31:0]           hrdata,
  // Analog side: comparisons indexed by {positive, negative} select
  input  wire logic [1:0][3:0]       comp_gt,
  output      dcc_pkg::dcc_ana_type  ana,
  // Comparator pins
  output      logic [1:0]            cmp_pin_o,
  output      logic [1:0]            cmp_pin_oe,
  // Power management
  input  wire logic                  total_power_down,
  output      logic                  wake,
  // Interrupt
  output      logic                  irq
);
  import dcc_pkg::*;

  localparam int CW = $clog2(SETTLE_CYC + 1);
  localparam logic [CW-1:0] SETTLE_END = CW'(SETTLE_CYC);

  ////////////////////////////////////////////////////////////////////
  // Declarations

  dcc_ctrl_type [1:0] ctrl_reg;
  logic [1:0]         flag_reg;
  logic [1:0]         mask_reg;
  logic               ec_reg;
  logic               gea_reg;
  logic               apd_reg;
  logic [1:0]         sync1_reg;
  logic [1:0]         sync2_reg;
  logic [1:0]         prev_reg;
  logic [CW-1:0]      cnt_reg [2];
  logic [1:0]         settled;
  logic [1:0]         en_eff;
  logic [1:0]         raw;
  logic [1:0]         change;
  logic [1:0]         clr;
  logic [1:0]         wr_ctrl;
  logic               wr_pend_reg;
  logic [31:0]        waddr_reg;
  logic [31:0]        rdata_next;
  logic [31:0]        hrdata_reg;
  logic               take;
  logic               wr_irq_en;
  logic               wr_aux;
  logic               wr_status;
  logic               wr_mask;
  logic               pending;

  ////////////////////////////////////////////////////////////////////
  // Address decode

  // Upper address bits must be zero, so aliases do not hit
  function automatic logic dcc_hit(input logic [31:0] a,
                                   input logic [`DCC_IDX_W-1:0] i);
    return (a[31:`DCC_IDX_W+2] == '0) && (a[`DCC_IDX_W+1:2] == i);
  endfunction

  // Read value of one comparator control register
  function automatic logic [7:0] dcc_ctrl_rd(input dcc_ctrl_type c,
                                             input logic res,
                                             input logic flg);
    logic [7:0] v;
    v = 8'h00;
    v[`DCC_B_EN]   = c.en;
    v[`DCC_B_POS]  = c.pos_sel;
    v[`DCC_B_NEG]  = c.neg_sel;
    v[`DCC_B_OE]   = c.pin_oe;
    v[`DCC_B_RES]  = res;
    v[`DCC_B_FLAG] = flg;
    return v;
  endfunction

  // Zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_reg;
  assign take      = hsel & htrans[1] & hready;

  ////////////////////////////////////////////////////////////////////
  // Bus address phase capture

  // Write data arrives one cycle later, so the address is held
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      waddr_reg   <= `DCC_ZERO32;
    end else begin
      wr_pend_reg <= take & hwrite;
      if (take) begin
        waddr_reg <= haddr;
      end
    end
  end

  // [R2] Register placement by index
  assign wr_ctrl[0] = wr_pend_reg & dcc_hit(waddr_reg, `DCC_IDX_CTRL_ONE);
  assign wr_ctrl[1] = wr_pend_reg & dcc_hit(waddr_reg, `DCC_IDX_CTRL_TWO);
  assign wr_irq_en  = wr_pend_reg & dcc_hit(waddr_reg, `DCC_IDX_IRQ_EN);
  assign wr_aux     = wr_pend_reg & dcc_hit(waddr_reg, `DCC_IDX_AUX_PWR);
  assign wr_status  = wr_pend_reg & dcc_hit(waddr_reg, `DCC_IDX_STATUS);
  assign wr_mask    = wr_pend_reg & dcc_hit(waddr_reg, `DCC_IDX_MASK);

  ////////////////////////////////////////////////////////////////////
  // Read path

  // Read mux sampled in the address phase; unmapped reads zero
  always_comb begin
    rdata_next = `DCC_ZERO32;
    if (dcc_hit(haddr, `DCC_IDX_CTRL_ONE)) begin
      rdata_next[7:0] = dcc_ctrl_rd(ctrl_reg[0], sync2_reg[0], flag_reg[0]);
    end else if (dcc_hit(haddr, `DCC_IDX_CTRL_TWO)) begin
      rdata_next[7:0] = dcc_ctrl_rd(ctrl_reg[1], sync2_reg[1], flag_reg[1]);
    end else if (dcc_hit(haddr, `DCC_IDX_IRQ_EN)) begin
      rdata_next[`DCC_B_EC]  = ec_reg;
      rdata_next[`DCC_B_GEA] = gea_reg;
    end else if (dcc_hit(haddr, `DCC_IDX_AUX_PWR)) begin
      rdata_next[`DCC_B_APD] = apd_reg;
    end else if (dcc_hit(haddr, `DCC_IDX_STATUS)) begin
      rdata_next[1:0] = flag_reg;
      rdata_next[`DCC_B_SETTLED+1:`DCC_B_SETTLED] = settled;
    end else if (dcc_hit(haddr, `DCC_IDX_MASK)) begin
      rdata_next[1:0] = mask_reg;
    end
  end

  // Read data register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_reg <= `DCC_ZERO32;
    end else if (take && !hwrite) begin
      hrdata_reg <= rdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Control registers

  // [R13] Total power-down wins over a write to the enable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg <= {2{`DCC_CTRL_RST}};
    end else begin
      for (int n = 0; n < 2; n++) begin
        if (wr_ctrl[n]) begin
          // [R6] [R7] [R8] Select and enable bits stored
          ctrl_reg[n].en      <= hwdata[`DCC_B_EN];
          ctrl_reg[n].pos_sel <= hwdata[`DCC_B_POS];
          ctrl_reg[n].neg_sel <= hwdata[`DCC_B_NEG];
          ctrl_reg[n].pin_oe  <= hwdata[`DCC_B_OE];
        end
        if (total_power_down) begin
          ctrl_reg[n].en <= 1'b0;
        end
      end
    end
  end

  // Interrupt enables, power and mask
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ec_reg   <= 1'b0;
      gea_reg  <= 1'b0;
      apd_reg  <= 1'b0;
      mask_reg <= `DCC_MASK_RST;
    end else begin
      if (wr_irq_en) begin
        ec_reg  <= hwdata[`DCC_B_EC];
        gea_reg <= hwdata[`DCC_B_GEA];
      end
      if (wr_aux) begin
        apd_reg <= hwdata[`DCC_B_APD];
      end
      if (wr_mask) begin
        mask_reg <= hwdata[1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Analog controls and pins

  // [R15] Aux power bit and total power-down cut the cells
  assign ana.power_down = apd_reg | total_power_down;
  assign en_eff[0] = ctrl_reg[0].en & ~ana.power_down;
  assign en_eff[1] = ctrl_reg[1].en & ~ana.power_down;
  assign ana.enable = en_eff;
  assign ana.positive_input_select = {ctrl_reg[1].pos_sel, ctrl_reg[0].pos_sel};
  assign ana.negative_input_select = {ctrl_reg[1].neg_sel, ctrl_reg[0].neg_sel};

  // [R1] [R11] Selected comparison, high while disabled
  always_comb begin
    for (int n = 0; n < 2; n++) begin
      if (en_eff[n]) begin
        raw[n] = comp_gt[n][{ctrl_reg[n].pos_sel, ctrl_reg[n].neg_sel}];
      end else begin
        raw[n] = 1'b1;
      end
    end
  end

  // [R5] Raw result to the pin, no clock in the path
  assign cmp_pin_oe[0] = ctrl_reg[0].pin_oe & en_eff[0];
  assign cmp_pin_oe[1] = ctrl_reg[1].pin_oe & en_eff[1];
  assign cmp_pin_o     = raw & cmp_pin_oe;

  ////////////////////////////////////////////////////////////////////
  // Result synchroniser and change flags

  // [R4] Two stages; reset state matches the forced-high idle level
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_reg <= 2'h3;
      sync2_reg <= 2'h3;
      prev_reg  <= 2'h3;
    end else begin
      sync1_reg <= raw;
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  // [R17] Difference against the previous cycle
  assign change = sync2_reg ^ prev_reg;

  // Clear by zero in the control register or one in status
  assign clr[0] = (wr_ctrl[0] & ~hwdata[`DCC_B_FLAG]) | (wr_status & hwdata[0]);
  assign clr[1] = (wr_ctrl[1] & ~hwdata[`DCC_B_FLAG]) | (wr_status & hwdata[1]);

  // [R3] Sticky flags; a change in the clear cycle is kept
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flag_reg <= 2'h0;
    end else begin
      for (int n = 0; n < 2; n++) begin
        if (change[n]) begin
          flag_reg[n] <= 1'b1;
        end else if (clr[n]) begin
          flag_reg[n] <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Settling timers

  // [R8] Counts from enable; software may poll it instead of waiting
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_reg[0] <= '0;
      cnt_reg[1] <= '0;
    end else begin
      for (int n = 0; n < 2; n++) begin
        if (!en_eff[n]) begin
          cnt_reg[n] <= '0;
        end else if (cnt_reg[n] != SETTLE_END) begin
          cnt_reg[n] <= cnt_reg[n] + 1'b1;
        end
      end
    end
  end

  assign settled[0] = (cnt_reg[0] == SETTLE_END);
  assign settled[1] = (cnt_reg[1] == SETTLE_END);

  ////////////////////////////////////////////////////////////////////
  // Interrupt and wake

  assign pending = |(flag_reg & mask_reg);

  // [R10] One shared request behind local and global enable
  assign irq = pending & ec_reg & gea_reg;

  // [R14] Wake ignores the global enable, not in total power-down
  assign wake = pending & ec_reg & ~total_power_down;

  ////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  change_flag_a: assert property ( // [R3]
    change[0] |=> flag_reg[0])
    else $error("change did not set flag one");

  flag_hold_a: assert property ( // [R3]
    flag_reg[1] && !clr[1] |=> flag_reg[1])
    else $error("flag two dropped without clear");

  sync_delay_a: assert property ( // [R4]
    sync2_reg[0] == $past(raw[0], 2))
    else $error("result one not two cycles behind raw");

  disabled_high_a: assert property ( // [R11]
    !en_eff[1] [*3] |-> sync2_reg[1])
    else $error("disabled comparator two not high");

  pin_route_a: assert property ( // [R5]
    cmp_pin_o[0] |-> ctrl_reg[0].pin_oe && en_eff[0])
    else $error("pin one driven while not routed");

  tpd_off_a: assert property ( // [R13]
    total_power_down |=> !ctrl_reg[0].en && !ctrl_reg[1].en)
    else $error("enable kept in total power-down");

  irq_gate_a: assert property ( // [R10]
    irq |-> ec_reg && gea_reg && (flag_reg != 2'h0))
    else $error("interrupt without enabled flag");

  wake_up_a: assert property ( // [R14]
    $rose(|(flag_reg & mask_reg)) && ec_reg && !total_power_down |-> wake)
    else $error("no wake on enabled change");

  set_wins_a: assert property ( // [R17]
    change[1] && clr[1] |=> flag_reg[1])
    else $error("clear beat a change on flag two");

  settle_wait_a: assert property ( // [R8]
    $rose(en_eff[0]) |=> !settled[0] [*8])
    else $error("settled too early");

  power_cut_a: assert property ( // [R15]
    apd_reg |-> ana.power_down && en_eff == 2'h0)
    else $error("comparators live while powered down");

endmodule : dcc_top

// ===== inc/dcc_defs.svh
// Constants of the dual comparator control block.
// Assumes inclusion by bare name from the package and the top module.
`ifndef DCC_DEFS_SVH
`define DCC_DEFS_SVH

// Register indices; byte address is four times the index
`define DCC_IDX_W        10
`define DCC_IDX_CTRL_ONE 10'h0ac
`define DCC_IDX_CTRL_TWO 10'h0ad
`define DCC_IDX_IRQ_EN   10'h0b0
`define DCC_IDX_AUX_PWR  10'h0b1
`define DCC_IDX_STATUS   10'h0b2
`define DCC_IDX_MASK     10'h0b3

// Control register fields
`define DCC_B_FLAG 0
`define DCC_B_RES  1
`define DCC_B_OE   2
`define DCC_B_NEG  3
`define DCC_B_POS  4
`define DCC_B_EN   5

// Interrupt enable, power and status fields
`define DCC_B_EC      0
`define DCC_B_GEA     1
`define DCC_B_APD     5
`define DCC_B_SETTLED 2

// Reset values
`define DCC_CTRL_RST 4'h0
`define DCC_MASK_RST 2'h3
`define DCC_ZERO32   32'h0000_0000

// Settling time after enable
`define DCC_SETTLE_NS  10000
`define DCC_CLK_NS     10
`define DCC_SETTLE_CYC ((`DCC_SETTLE_NS + `DCC_CLK_NS - 1) / `DCC_CLK_NS)

`endif

// ===== inc/dcc_pkg.sv
// Types of the dual comparator control block.
// Assumes dcc_defs.svh on the include path.
`include "dcc_defs.svh"

package dcc_pkg;

  // Stored control bits of one comparator
  typedef struct packed {
    logic en;
    logic pos_sel;
    logic neg_sel;
    logic pin_oe;
  } dcc_ctrl_type;

  // Controls toward the analog comparator cells
  typedef struct packed {
    logic       power_down;
    logic [1:0] enable;
    logic [1:0] positive_input_select;
    logic [1:0] negative_input_select;
  } dcc_ana_type;

endpackage : dcc_pkg

// ===== verif/dcc_top_bench.sv
// Self-checking bench for the dual comparator control block.
// Assumes dcc_pkg compiled first and dcc_defs.svh on the include path.
module dcc_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import dcc_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  localparam logic [31:0] A_ONE = 32'h0000_02b0;
  localparam logic [31:0] A_TWO = 32'h0000_02b4;
  localparam logic [31:0] A_IEN = 32'h0000_02c0;
  localparam logic [31:0] A_PWR = 32'h0000_02c4;
  localparam logic [31:0] A_STS = 32'h0000_02c8;
  localparam logic [31:0] A_MSK = 32'h0000_02cc;

  logic              hclk = 1'b0;
  logic              hresetn = 1'b0;
  logic              hsel = 1'b0;
  logic [31:0]       haddr = '0;
  logic [1:0]        htrans = 2'b00;
  logic              hwrite = 1'b0;
  logic [31:0]       hwdata = '0;
  logic              hready;
  logic              hreadyout;
  logic [31:0]       hrdata;
  logic              hresp;
  logic [1:0][3:0]   comp_gt = '0;
  dcc_ana_type       ana;
  logic [1:0]        cmp_pin_o;
  logic [1:0]        cmp_pin_oe;
  logic              total_power_down = 1'b0;
  logic              wake;
  logic              irq;
  logic              mon_go = 1'b0;
  logic [2:0]        mon_code = '0;
  logic [31:0]       exp_q[$];
  int                error_cnt = 0;
  int                samples_checked = 0;

  // Single slave, so its ready is the bus ready
  assign hready = hreadyout;
  always #5 hclk = ~hclk;

  dcc_top #(.SETTLE_CYC(16)) uut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .comp_gt(comp_gt), .ana(ana),
    .cmp_pin_o(cmp_pin_o), .cmp_pin_oe(cmp_pin_oe),
    .total_power_down(total_power_down), .wake(wake), .irq(irq));

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] expv);
    samples_checked++;
    if (seen !== expv) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, expv);
    end
  endtask

  task automatic conclude();
    $display("errors %0d, comparisons %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Monitor: takes the oldest note whenever a result is flagged
  always @(posedge hclk) begin
    if (mon_go) begin
      case (mon_code)
        3'd0: chk(hrdata, exp_q.pop_front());
        3'd1: chk({31'h0, irq}, exp_q.pop_front());
        3'd2: chk({31'h0, wake}, exp_q.pop_front());
        3'd3: chk({30'h0, cmp_pin_o}, exp_q.pop_front());
        3'd4: chk({30'h0, cmp_pin_oe}, exp_q.pop_front());
        3'd5: chk({25'h0, ana}, exp_q.pop_front());
        3'd6: chk({30'h0, ana.enable}, exp_q.pop_front());
        default: chk({30'h0, hreadyout, hresp}, exp_q.pop_front());
      endcase
    end
  end

  // One single-word transfer; read data taken at the data-phase edge
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    mon_code <= 3'd0;
    mon_go <= !w;
    do @(posedge hclk); while (hready !== 1'b1);
    mon_go <= 1'b0;
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, '0);
  endtask

  task automatic look(input logic [2:0] code, input logic [31:0] e);
    @(posedge hclk);
    exp_q.push_back(e);
    mon_code <= code;
    mon_go <= 1'b1;
    @(posedge hclk);
    mon_go <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Watchdog: the whole sequence needs well under 2000 cycles
  initial begin
    #200000;
    error_cnt++;
    conclude();
  end

  initial begin
    logic [31:0] a;
    logic [5:0]  cfg;
    logic [3:0]  g;
    logic        v;
    void'($urandom(32'hca96));
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // Reset values, unmapped place reads zero
    rd(A_ONE, 32'h2);
    rd(A_TWO, 32'h2);
    rd(A_MSK, 32'h3);
    rd(A_IEN, 32'h0);
    rd(32'h0000_02d0, 32'h0);
    look(3'd7, 32'h2);
    // Every selection with the interrupt off, then a toggle
    for (int n = 0; n < 2; n++) begin
      a = n ? A_TWO : A_ONE;
      for (int c = 0; c < 4; c++) begin
        cfg = 6'h24 | (6'(c) << 3);
        g = 4'($urandom);
        v = g[c];
        comp_gt[n] <= g;
        bus(1'b1, a, 32'(cfg));
        repeat (6) @(posedge hclk);
        bus(1'b1, a, 32'(cfg));
        rd(a, 32'(cfg) | (32'(v) << 1));
        look(3'd3, 32'(v) << n);
        look(3'd4, 32'h1 << n);
        look(3'd5, {25'h0, 1'b0, 2'(1 << n), 2'(c[1] << n), 2'(c[0] << n)});
        g = 4'($urandom);
        g[c] = !v;
        comp_gt[n] <= g;
        repeat (6) @(posedge hclk);
        rd(a, 32'(cfg) | (32'(!v) << 1) | 32'h1);
        bus(1'b1, a, 32'h0);
      end
    end
    // Disable with low result raises result and flag
    comp_gt[0] <= 4'h0;
    bus(1'b1, A_ONE, 32'h20);
    repeat (6) @(posedge hclk);
    bus(1'b1, A_ONE, 32'h20);
    repeat (4) @(posedge hclk);
    // Interrupt already off; flag set after disable
    bus(1'b1, A_ONE, 32'h0);
    bus(1'b1, A_TWO, 32'h0);
    repeat (6) @(posedge hclk);
    rd(A_ONE, 32'h3);
    rd(A_STS, 32'h1);
    bus(1'b1, A_IEN, 32'h3);
    look(3'd1, 32'h1);
    bus(1'b1, A_MSK, 32'h2);
    look(3'd1, 32'h0);
    bus(1'b1, A_MSK, 32'h3);
    bus(1'b1, A_IEN, 32'h1);
    look(3'd1, 32'h0);
    look(3'd2, 32'h1);
    total_power_down <= 1'b1;
    look(3'd2, 32'h0);
    total_power_down <= 1'b0;
    // Service clears the flag, no new request
    bus(1'b1, A_STS, 32'h1);
    bus(1'b1, A_IEN, 32'h3);
    look(3'd1, 32'h0);
    rd(A_ONE, 32'h2);
    // Interrupt off while comparator two settles
    bus(1'b1, A_IEN, 32'h0);
    comp_gt[1] <= 4'hf;
    bus(1'b1, A_TWO, 32'h20);
    rd(A_STS, 32'h0);
    repeat (20) @(posedge hclk);
    rd(A_STS, 32'h8);
    // Change lands in the clear cycle, set wins
    bus(1'b1, A_IEN, 32'h1);
    comp_gt[1] <= 4'he;
    @(posedge hclk);
    bus(1'b1, A_TWO, 32'h20);
    rd(A_TWO, 32'h21);
    look(3'd2, 32'h1);
    bus(1'b1, A_IEN, 32'h0);
    bus(1'b1, A_STS, 32'h2);
    // Total power-down drops both enables, flag rises
    total_power_down <= 1'b1;
    repeat (2) @(posedge hclk);
    look(3'd6, 32'h0);
    total_power_down <= 1'b0;
    rd(A_TWO, 32'h3);
    // Aux power bit keeps stored enable but powers down
    bus(1'b1, A_PWR, 32'h20);
    bus(1'b1, A_ONE, 32'h20);
    look(3'd5, 32'h40);
    rd(A_PWR, 32'h20);
    rd(A_ONE, 32'h22);
    repeat (4) @(posedge hclk);
    conclude();
  end
endmodule // dcc_top_bench
